// ---- include/pin_share_consts.svh ----
// Pin indices, strap positions, reset values and clock figures of the pin-share block
`ifndef PIN_SHARE_CONSTS_SVH
`define PIN_SHARE_CONSTS_SVH
// Clock figures in MHz, and the step of the reference clock accumulator
`define SYS_CLK_MHZ      125
`define REF_CLK_MHZ      20
`define REF_NCO_STEP     (2 * `REF_CLK_MHZ)
`define REF_NCO_MOD      `SYS_CLK_MHZ
// Address pad positions
`define AP_RXD3          1
`define AP_EE_IN         2
`define AP_STYLE         6
`define AP_COL           6
`define AP_TXC           7
`define AP_TXEN          8
`define AP_VARIANT       8
`define AP_TXD0          9
`define AP_LOCK          9
`define AP_ACTIVITY      10
`define AP_REF_CLK       11
`define AP_LINK          12
`define AP_SLOW          13
`define AP_CRS           14
`define AP_RXC           15
`define AP_RXD0          16
`define AP_TOP           17
// Boot data pad positions
`define DP_RXER          3
`define DP_RXDV          4
`define DP_RXD1          5
`define DP_RXD2          6
`define DP_MDIO          7
// Output enables of the EEPROM pads: input, then three outputs
`define EE_PAD_OE        4'he
// Reset values
`define RST_MII_SEL      1'h0
`define RST_LINK_STATUS  1'h0
`endif

// ---- include/pin_share_pkg.sv ----
// Types shared by the pin-share block and its users
package pin_share_pkg;
    // Pin ownership decided by the straps
    typedef enum logic [3:0] {
        MODE_NORMAL   = 4'h1,
        MODE_EXTERNAL = 4'h2,
        MODE_TEST     = 4'h4,
        MODE_RESERVED = 4'h8
    } mode_t;
    // What the boot ROM controller wants on the pins
    typedef struct packed {
        logic [17:0] addr;
        logic [7:0]  ad;
        logic        ad_oe;
        logic        cs_n;
    } boot_drive_t;
    typedef struct packed {
        logic sel;
        logic clock;
        logic data_out;
    } eeprom_drive_t;
    typedef struct packed {
        logic slow;
        logic fast;
        logic duplex;
        logic activity;
    } led_drive_t;
    // Transmit side of the link, in the link clock domain
    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } mac_tx_t;
    // Receive side of the link, in the link clock domain
    typedef struct packed {
        logic       col;
        logic       crs;
        logic       dv;
        logic       er;
        logic [3:0] data;
    } mac_rx_t;
endpackage

// ---- rtl/bit_sync.sv ----
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // No reset: the chain must keep sampling straps while reset is held
    always_ff @(posedge clk)
    begin
        meta <= d;
        q    <= meta;
    end
endmodule
`default_nettype wire

// ---- rtl/ref_clock_div.sv ----
// Fractional divider making the PHY reference clock from the system clock
`timescale 1ns/10ps
`default_nettype none
`include "pin_share_consts.svh"
module ref_clock_div (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic run,
    output logic      ref_clk
);
    logic [7:0] acc;
    wire  [8:0] sum  = {1'b0, acc} + 9'(`REF_NCO_STEP);
    wire        wrap = sum >= 9'(`REF_NCO_MOD);

    // Accumulator toggles twice per reference period; edges jitter by one cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst || !run)
        begin
            acc     <= 8'h00;
            ref_clk <= 1'b0;
        end
        else
        begin
            acc     <= wrap ? 8'(sum - 9'(`REF_NCO_MOD)) : sum[7:0];
            ref_clk <= ref_clk ^ wrap;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ext_phy_bootrom_pin_share.sv ----
// Sharing of boot ROM pins with an external PHY link, chosen by straps and software
`timescale 1ns/10ps
`default_nettype none
`include "pin_share_consts.svh"
// Overview of operation
// - External PHY link and boot ROM port share one pin set, one owner at a time.
// - Test one low, test two high: normal boot ROM use, clock-run strap ignored.
// - Both tests low, clock-run low: external PHY; variant strap low MII, high serial.
// - Test one high: internal test mode regardless of every other strap.
// - Lock strap high: variant fixed by straps, software cannot change it.
// - Lock strap low: variant follows operation-mode register bit 18.
// - Software bit one selects MII, zero selects serial, changeable at run time.
// - Normal mode: style strap low multiplexed port, high direct address port.
// - MII: transmit bits three, two, one on data pads 0-2, bit zero on address pad 9.
// - MII: receive error, valid, data 1, 2 on data pads 3-6; data 0 on address 16.
// - MII: management data on data pad seven, management clock on chip select.
// - Serial: data, chip select and low address pads keep multiplexed boot use.
// - Serial: inputs on address 6, 7, 14, 15, 16; enable and data out on 8, 9.
// - MII: inputs on address 6, 7, 14, 15; transmit enable out on address 8.
// - External modes: four EEPROM pads keep their function and direction.
// - External modes: free-running 20 MHz reference clock on duplex indicator pad.
// - PHY drives link status on speed pad; reflected and changes flagged.
// - External modes: activity, slow-speed and top pads left idle; address pad 0 idle in MII only.
module ext_phy_bootrom_pin_share
    import pin_share_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          phy_link_clk,
    input  wire logic          test_strap1,
    input  wire logic          test_strap2,
    input  wire logic          clkrun_n,
    input  wire logic [7:0]    data_pad_in,
    output logic      [7:0]    data_pad_out,
    output logic      [7:0]    data_pad_oe,
    output logic               chip_sel_pad_out,
    output logic               chip_sel_pad_oe,
    input  wire logic [17:0]   addr_pad_in,
    output logic      [17:0]   addr_pad_out,
    output logic      [17:0]   addr_pad_oe,
    input  wire boot_drive_t   boot,
    output logic      [7:0]    boot_ad_in,
    input  wire eeprom_drive_t eeprom,
    output logic               eeprom_data_in,
    input  wire led_drive_t    leds,
    input  wire logic          mii_mode_bit,
    input  wire logic          mgmt_clock,
    input  wire logic          mgmt_data_out,
    input  wire logic          mgmt_data_oe,
    output logic               mgmt_data_in,
    input  wire mac_tx_t       mac_tx,
    output mac_rx_t            mac_rx,
    output mode_t              mode,
    output logic               boot_direct,
    output logic               mii_selected,
    output logic               gp_link_status,
    output logic               link_change
);
    logic [5:0] strap_s;
    logic [1:0] slow_s;
    logic       lock;
    logic       strap_variant;
    logic       ref_clk;
    logic [2:0] link_ctl;
    mac_tx_t    tx_q;
    mac_rx_t    rx_raw;

    // Strap pins pass the synchroniser before any decode
    bit_sync #(.W(6)) u_strap_sync (
        .clk (clk_sys),
        .d   ({test_strap1, test_strap2, clkrun_n, addr_pad_in[`AP_LOCK],
               addr_pad_in[`AP_VARIANT], addr_pad_in[`AP_STYLE]}),
        .q   (strap_s)
    );

    // Strap decode; test one outranks everything, test two next
    wire   s_test1  = strap_s[5];
    wire   s_test2  = strap_s[4];
    wire   s_clkrun = strap_s[3];
    wire   s_lock   = strap_s[2];
    wire   s_var    = strap_s[1];
    wire   s_style  = strap_s[0];
    mode_t next_mode;
    assign next_mode = s_test1  ? MODE_TEST :
                       s_test2  ? MODE_NORMAL :
                       !s_clkrun ? MODE_EXTERNAL :
                       MODE_RESERVED;

    // Straps are caught only while reset is held, then frozen
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mode          <= next_mode;
            boot_direct   <= s_style;
            lock          <= s_lock;
            strap_variant <= s_var;
        end
    end

    wire ext = (mode == MODE_EXTERNAL);

    // Variant: strap when locked, otherwise the software bit, live
    wire next_mii = lock ? !strap_variant : mii_mode_bit;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            mii_selected <= `RST_MII_SEL;
        else
            mii_selected <= next_mii;
    end

    // Slow pins back to the system side: link status and EEPROM data
    bit_sync #(.W(2)) u_slow_sync (
        .clk (clk_sys),
        .d   ({addr_pad_in[`AP_LINK], addr_pad_in[`AP_EE_IN]}),
        .q   (slow_s)
    );
    bit_sync #(.W(8)) u_data_sync (
        .clk (clk_sys),
        .d   (data_pad_in),
        .q   (boot_ad_in)
    );
    assign eeprom_data_in = slow_s[0];
    assign mgmt_data_in   = boot_ad_in[`DP_MDIO];

    // Link status mirror and change pulse, only while the PHY owns the pin
    always_ff @(posedge clk_sys)
    begin
        if (srst || !ext)
        begin
            gp_link_status <= `RST_LINK_STATUS;
            link_change    <= 1'b0;
        end
        else
        begin
            gp_link_status <= slow_s[1];
            link_change    <= slow_s[1] != gp_link_status;
        end
    end

    // Reference clock runs whenever an external PHY is attached
    ref_clock_div u_ref_clk (
        .clk_sys (clk_sys),
        .srst    (srst),
        .run     (ext),
        .ref_clk (ref_clk)
    );

    // Levels into the link domain: reset, ownership and variant
    bit_sync #(.W(3)) u_link_ctl_sync (
        .clk (phy_link_clk),
        .d   ({srst, ext, mii_selected}),
        .q   (link_ctl)
    );
    wire link_rst = link_ctl[2];
    wire ext_l    = link_ctl[1];
    wire mii_l    = link_ctl[0];

    // Transmit register on the PHY transmit clock; serial uses bit zero only
    always_ff @(posedge phy_link_clk)
    begin
        if (link_rst || !ext_l)
            tx_q <= '0;
        else
            tx_q <= {mac_tx.en, mii_l ? mac_tx.data : {3'h0, mac_tx.data[0]}};
    end

    // Receive pads gathered per variant, then synchronised on the link clock
    always_comb
    begin
        rx_raw      = '0;
        rx_raw.col  = addr_pad_in[`AP_COL];
        rx_raw.crs  = addr_pad_in[`AP_CRS];
        rx_raw.data = {3'h0, addr_pad_in[`AP_RXD0]};
        if (mii_l)
        begin
            rx_raw.er   = data_pad_in[`DP_RXER];
            rx_raw.dv   = data_pad_in[`DP_RXDV];
            rx_raw.data = {addr_pad_in[`AP_RXD3], data_pad_in[`DP_RXD2],
                           data_pad_in[`DP_RXD1], addr_pad_in[`AP_RXD0]};
        end
        if (!ext_l)
            rx_raw = '0;
    end
    bit_sync #(.W(8)) u_rx_sync (
        .clk (phy_link_clk),
        .d   (rx_raw),
        .q   (mac_rx)
    );

    // Pad ownership; test and reserved codes release every pad
    always_comb
    begin
        data_pad_out     = '0;
        data_pad_oe      = '0;
        chip_sel_pad_out = 1'b1;
        chip_sel_pad_oe  = 1'b0;
        addr_pad_out     = '0;
        addr_pad_oe      = '0;
        case (mode)
            MODE_NORMAL:
            begin
                data_pad_out     = boot.ad;
                data_pad_oe      = {8{boot.ad_oe}};
                chip_sel_pad_out = boot.cs_n;
                chip_sel_pad_oe  = 1'b1;
                if (boot_direct)
                begin
                    addr_pad_out = boot.addr;
                    addr_pad_oe  = '1;
                end
                else
                begin
                    addr_pad_out[1:0]   = boot.addr[1:0];
                    addr_pad_oe[1:0]    = 2'h3;
                    addr_pad_out[5:2]   = {eeprom.sel, eeprom.clock, eeprom.data_out, 1'b0};
                    addr_pad_oe[5:2]    = `EE_PAD_OE;
                    addr_pad_out[13:10] = leds;
                    addr_pad_oe[13:10]  = 4'hf;
                    addr_pad_out[`AP_TOP] = boot.addr[`AP_TOP];
                    addr_pad_oe[`AP_TOP]  = 1'b1;
                end
            end
            MODE_EXTERNAL:
            begin
                addr_pad_out[5:2] = {eeprom.sel, eeprom.clock, eeprom.data_out, 1'b0};
                addr_pad_oe[5:2]  = `EE_PAD_OE;
                addr_pad_out[`AP_REF_CLK] = ref_clk;
                addr_pad_oe[`AP_REF_CLK]  = 1'b1;
                addr_pad_out[`AP_TXEN]    = tx_q.en;
                addr_pad_out[`AP_TXD0]    = tx_q.data[0];
                addr_pad_oe[`AP_TXEN]     = 1'b1;
                addr_pad_oe[`AP_TXD0]     = 1'b1;
                if (mii_selected)
                begin
                    data_pad_out[2:0] = {tx_q.data[1], tx_q.data[2], tx_q.data[3]};
                    data_pad_oe[2:0]  = 3'h7;
                    data_pad_out[`DP_MDIO] = mgmt_data_out;
                    data_pad_oe[`DP_MDIO]  = mgmt_data_oe;
                    chip_sel_pad_out       = mgmt_clock;
                    chip_sel_pad_oe        = 1'b1;
                end
                else
                begin
                    data_pad_out      = boot.ad;
                    data_pad_oe       = {8{boot.ad_oe}};
                    chip_sel_pad_out  = boot.cs_n;
                    chip_sel_pad_oe   = 1'b1;
                    addr_pad_out[1:0] = boot.addr[1:0];
                    addr_pad_oe[1:0]  = 2'h3;
                end
            end
            default:
            begin
                data_pad_oe = '0;
            end
        endcase
    end

    // Checks beside the logic they guard
    a_test_release: assert property (@(posedge clk_sys) disable iff (srst)
        mode == MODE_TEST |-> addr_pad_oe == '0 && data_pad_oe == '0 && !chip_sel_pad_oe)
        else $error("pads driven in test mode");
    a_normal_boot: assert property (@(posedge clk_sys) disable iff (srst)
        mode == MODE_NORMAL |-> chip_sel_pad_oe && chip_sel_pad_out == boot.cs_n)
        else $error("boot chip select not routed in normal mode");
    a_mode_held: assert property (@(posedge clk_sys)
        !srst && $past(!srst) |-> $stable(mode) && $stable(boot_direct))
        else $error("mode changed outside reset");
    a_locked_variant: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && $past(lock) |-> mii_selected == !strap_variant)
        else $error("locked variant not taken from strap");
    a_sw_variant: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(srst) && !$past(lock) |-> mii_selected == $past(mii_mode_bit))
        else $error("software variant bit not followed");
    a_eeprom_kept: assert property (@(posedge clk_sys) disable iff (srst)
        ext |-> addr_pad_oe[5:2] == `EE_PAD_OE && addr_pad_out[4] == eeprom.clock)
        else $error("eeprom pads disturbed in external mode");
    a_idle_pads: assert property (@(posedge clk_sys) disable iff (srst)
        ext |-> !addr_pad_oe[`AP_ACTIVITY] && !addr_pad_oe[`AP_SLOW] &&
                !addr_pad_oe[`AP_TOP] && (!addr_pad_oe[0] || !mii_selected))
        else $error("unconnected pad driven in external mode");
    a_mii_mgmt: assert property (@(posedge clk_sys) disable iff (srst)
        ext && mii_selected |-> chip_sel_pad_out == mgmt_clock &&
                                data_pad_oe[`DP_MDIO] == mgmt_data_oe)
        else $error("management pins not routed in MII mode");
    a_serial_boot: assert property (@(posedge clk_sys) disable iff (srst)
        ext && !mii_selected |-> data_pad_out == boot.ad && addr_pad_out[1:0] == boot.addr[1:0])
        else $error("boot pads reassigned in serial mode");
    a_link_flag: assert property (@(posedge clk_sys) disable iff (srst)
        ext && $past(ext) && link_change |-> $past(gp_link_status) != $past(slow_s[1]))
        else $error("link change flagged without a status change");
endmodule
`default_nettype wire

// ---- verification/phy_model.sv ----
// Behavioural external PHY with strap resistors, facing the shared pads
`timescale 1ns/10ps
`default_nettype none
module phy_model
    import pin_share_pkg::*;
(
    input  wire logic        clk_link,
    input  wire logic        srst,
    input  wire logic [17:0] straps,
    input  wire logic        link_up,
    input  wire logic        mdio_bit,
    input  wire logic        ee_bit,
    input  wire mac_rx_t     rx,
    output logic      [17:0] addr_drv,
    output logic      [7:0]  data_drv
);
    logic [7:0] junk = 8'h5a;
    mac_rx_t    rx_q = 8'h00;
    // Receive pins launched just after the link clock edge
    always @(posedge clk_link)
    begin
        rx_q <= rx;
        junk <= ~junk;
    end
    // Idle lines toggle so a stale level never reads as a match
    always_comb
    begin
        addr_drv = {junk[1:0], junk, junk};
        data_drv = junk;
        addr_drv[1] = rx_q.data[3];
        addr_drv[2] = ee_bit;
        addr_drv[6] = rx_q.col;
        addr_drv[7] = clk_link;
        addr_drv[12] = link_up;
        addr_drv[14] = rx_q.crs;
        addr_drv[15] = clk_link;
        addr_drv[16] = rx_q.data[0];
        data_drv[3] = rx_q.er;
        data_drv[4] = rx_q.dv;
        data_drv[6:5] = rx_q.data[2:1];
        data_drv[7] = mdio_bit;
        // Board resistors win while reset holds the straps
        if (srst)
            addr_drv = straps;
    end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench of the pin-share block against an external PHY model
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pin_share_pkg::*;
;
    logic          clk_sys, clk_link, srst, t1, t2, ck;
    logic [17:0]   straps, a_out, a_oe, a_in, addr_drv, oe_a;
    logic [7:0]    d_out, d_oe, d_in, data_drv, boot_ad_in;
    logic          link_up, mdio_bit, ee_bit, mii_bit, mg_clk, mg_out, mg_oe;
    logic          cs_out, cs_oe, ee_in, mg_in, boot_direct, mii_sel, gp_link, link_chg;
    mac_rx_t       rx_pat, mac_rx;
    mac_tx_t       tx;
    boot_drive_t   boot;
    eeprom_drive_t ee;
    led_drive_t    leds;
    mode_t         mode;
    int            failures = 0;
    int            n_checks = 0;

    // Pad levels; design drive on address pads is ignored in reset since the straps own them
    assign oe_a = srst ? 18'h0 : a_oe;
    assign a_in = (oe_a & a_out) | (~oe_a & addr_drv);
    assign d_in = (d_oe & d_out) | (~d_oe & data_drv);

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Link clock offset so its edges never line up with the system clock
    initial
    begin
        clk_link = 1'b0;
        #37;
        forever #80 clk_link = ~clk_link;
    end

    ext_phy_bootrom_pin_share i_dut (.clk_sys(clk_sys), .srst(srst), .phy_link_clk(clk_link),
        .test_strap1(t1), .test_strap2(t2), .clkrun_n(ck), .data_pad_in(d_in),
        .data_pad_out(d_out), .data_pad_oe(d_oe), .chip_sel_pad_out(cs_out),
        .chip_sel_pad_oe(cs_oe), .addr_pad_in(a_in), .addr_pad_out(a_out), .addr_pad_oe(a_oe),
        .boot(boot), .boot_ad_in(boot_ad_in), .eeprom(ee), .eeprom_data_in(ee_in),
        .leds(leds), .mii_mode_bit(mii_bit), .mgmt_clock(mg_clk), .mgmt_data_out(mg_out),
        .mgmt_data_oe(mg_oe), .mgmt_data_in(mg_in), .mac_tx(tx), .mac_rx(mac_rx),
        .mode(mode), .boot_direct(boot_direct), .mii_selected(mii_sel),
        .gp_link_status(gp_link), .link_change(link_chg));

    phy_model i_phy (.clk_link(clk_link), .srst(srst), .straps(straps), .link_up(link_up),
        .mdio_bit(mdio_bit), .ee_bit(ee_bit), .rx(rx_pat), .addr_drv(addr_drv),
        .data_drv(data_drv));

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic mode_t exp_mode(input logic a, input logic b, input logic c);
        if (a)
            return MODE_TEST;
        if (b)
            return MODE_NORMAL;
        return c ? MODE_RESERVED : MODE_EXTERNAL;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Strap code: tests and clock-run, then style, variant, lock
    task automatic do_reset(input logic [5:0] s);
        @(posedge clk_sys);
        {t1, t2, ck} <= s[5:3];
        straps <= (18'(s[0]) << 9) | (18'(s[1]) << 8) | (18'(s[2]) << 6);
        srst <= 1'b1;
        // Long hold so the link domain sees several of its own clocks
        cyc(80);
        srst <= 1'b0;
        cyc(2);
    endtask

    // One burst of link traffic with random side inputs, then the pad map
    task automatic traffic(input logic m);
        @(posedge clk_link);
        tx <= 5'($urandom);
        rx_pat <= 8'($urandom);
        @(posedge clk_sys);
        boot <= 28'($urandom);
        ee <= 3'($urandom);
        {mg_clk, mg_out, mg_oe, mdio_bit, ee_bit} <= 5'($urandom);
        repeat (4) @(posedge clk_link);
        @(negedge clk_sys);
        check({a_out[9:8], a_oe[9:8]}, {tx.data[0], tx.en, 2'b11});
        check({a_oe[5:2], a_out[5:3], ee_in}, {4'he, ee, a_in[2]});
        check({a_oe[17], a_oe[13:12], a_oe[10]}, 4'h0);
        if (m)
        begin
            check({d_out[2:0], d_oe[2:0], a_oe[0]},
                  {tx.data[1], tx.data[2], tx.data[3], 3'h7, 1'b0});
            check(mac_rx, rx_pat);
            check({cs_out, cs_oe, d_oe[7], mg_in}, {mg_clk, 1'b1, mg_oe, d_in[7]});
        end
        else
        begin
            check({d_out, cs_out, a_out[1:0]}, {boot.ad, boot.cs_n, boot.addr[1:0]});
            check({mac_rx.col, mac_rx.crs, mac_rx.dv, mac_rx.er, mac_rx.data[0]},
                  {rx_pat.col, rx_pat.crs, 2'b00, rx_pat.data[0]});
        end
    endtask

    // Link status reaches the mirror in three edges, with one change pulse each time
    task automatic link_test();
        int first;
        int pulses;
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk_sys);
            link_up <= ~link_up;
            first = 0;
            pulses = 0;
            for (int c = 1; c <= 8; c++)
            begin
                @(negedge clk_sys);
                if (first == 0 && gp_link === link_up)
                    first = c;
                pulses += (link_chg === 1'b1);
            end
            check({8'(first), 8'(pulses)}, {8'h04, 8'h01});
        end
    endtask

    // Accumulator steps 40 of 125, so 250 cycles hold exactly 80 toggles
    task automatic ref_test();
        int t;
        logic p;
        t = 0;
        @(negedge clk_sys);
        p = a_out[11];
        repeat (250)
        begin
            @(negedge clk_sys);
            t += (a_out[11] !== p);
            p = a_out[11];
        end
        check({a_oe[11], 8'(t)}, {1'b1, 8'h50});
    endtask

    initial
    begin
        logic [5:0] s;
        srst = 1'b1;
        straps = 18'h0;
        {t1, t2, ck, link_up, mdio_bit, ee_bit, mii_bit, mg_clk, mg_out, mg_oe} = 10'h100;
        {rx_pat, tx, boot, ee, leds} = '0;
        void'($urandom(97359));
        // Every test and clock-run combination; later strap changes must not move the mode
        for (int i = 0; i < 8; i++)
        begin
            s = {i[2:0], 3'($urandom)};
            do_reset(s);
            check(mode, exp_mode(s[5], s[4], s[3]));
            check(boot_direct, s[2]);
            @(posedge clk_sys);
            {t1, t2, ck} <= ~s[5:3];
            straps <= ~straps;
            cyc(8);
            check({mode, boot_direct}, {exp_mode(s[5], s[4], s[3]), s[2]});
            if (s[5] || (!s[4] && s[3]))
                check({d_oe, a_oe, cs_oe, cs_out}, 28'h1);
        end
        // Normal use in both port styles
        for (int st = 0; st < 2; st++)
        begin
            do_reset({3'b010, st[0], 2'($urandom)});
            repeat (4)
            begin
                @(posedge clk_sys);
                boot <= 28'($urandom);
                leds <= 4'($urandom);
                @(negedge clk_sys);
                if (st == 1)
                    check({a_oe, a_out}, {18'h3ffff, boot.addr});
                else
                    check({d_out, d_oe, cs_out, a_out[13:10]},
                          {boot.ad, {8{boot.ad_oe}}, boot.cs_n, leds});
            end
            @(posedge clk_link);
            cyc(6);
            @(negedge clk_sys);
            check({gp_link, boot_ad_in}, {1'b0, d_in});
        end
        // External modes: every lock and variant strap against both software values
        for (int k = 0; k < 4; k++)
        begin
            do_reset({4'b0000, k[1], k[0]});
            for (int b = 0; b < 2; b++)
            begin
                @(posedge clk_sys);
                mii_bit <= b[0];
                cyc(2);
                check(mii_sel, k[0] ? !k[1] : b[0]);
                repeat (3) traffic(mii_sel);
            end
            link_test();
            ref_test();
        end
        print_verdict();
    end
endmodule
`default_nettype wire
